/* logic/cmbt_ctrl.sv */
/*
  CAN mode and bit-timing control: control and timing registers,
  mode handshake, abort, enable/busy, timestamp timer, wake filter,
  quantum divider and bit-phase sequencer.
  Assumes the protocol engine reports transaction activity, abort
  completion, mode safe points and valid receptions synchronously.
*/
`timescale 1ns/1ps
module cmbt_ctrl (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [31:0]                 reg_rdata,
  input  wire logic                        xact_busy,
  input  wire logic                        tx_abort_done,
  input  wire logic                        mode_ready,
  input  wire logic                        sys_idle,
  input  wire logic                        rx_valid_msg,
  input  wire logic                        can_rx,
  output logic                             tx_abort_req,
  output logic                             module_run,
  output logic      [2:0]                  mode_status,
  output logic                             mode_change_flag,
  output logic      [cmbt_pkg::TS_W-1:0]   rx_timestamp,
  output logic      [cmbt_pkg::TS_W-1:0]   timestamp_timer,
  output logic                             wake_line,
  output logic      [4:0]                  data_compare_count,
  output logic                             tq_tick,
  output logic                             sample_point,
  output logic                             sampled_bit,
  output logic                             bit_end,
  output logic      [3:0]                  phase_seg1_len,
  output logic      [3:0]                  phase_seg2_len,
  output logic      [3:0]                  prop_seg_len,
  output logic      [2:0]                  resync_jump_width,
  output logic                             triple_sample_en
);
  import cmbt_pkg::*;

  // ---------------------------------------------------------------
  // Alias arithmetic
  // ---------------------------------------------------------------
  function automatic logic [31:0] alias_wr(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [1:0]  kind
  );
    logic [31:0] r;
    r = old;
    unique case (kind)
      AL_WR:  r = wd;
      AL_CLR: r = old & ~wd;
      AL_SET: r = old | wd;
      AL_INV: r = old ^ wd;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [31:0]         ctrl_r;
  logic [31:0]         ctrl_nxt;
  logic [31:0]         cfg_r;
  logic [31:0]         cfg_nxt;
  logic                abort_r;
  logic                abort_nxt;
  logic [2:0]          mstat_r;
  logic                busy_r;
  logic                mode_change_flag_r;
  logic [31:0]         rdata_r;
  logic [TS_W-1:0]     tmr_r;
  logic [TS_W-1:0]     cap_r;
  logic [5:0]          div_r;
  logic                half_r;
  logic [4:0]          tq_r;
  logic [2:0]          smp_r;
  logic                bit_r;
  logic                wake_r;
  logic                rx_last_r;
  logic [7:0]          stab_r;
  cmbt_mode_st_t       mst_r;
  cmbt_mode_st_t       mst_nxt;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire [3:0]  a_base   = reg_addr[7:4];
  wire [1:0]  a_kind   = reg_addr[3:2];
  wire        hit_ctrl = (a_base == CTRL_BASE);
  wire        hit_cfg  = (a_base == CFG_BASE);
  wire        wr_ctrl  = reg_wr & hit_ctrl;
  wire        in_cfg   = (mstat_r == MODE_CONFIG);
  wire        wr_cfg   = reg_wr & hit_cfg & in_cfg;
  wire [31:0] ctrl_new = alias_wr(ctrl_r, reg_wdata, a_kind);
  wire [31:0] cfg_new  = alias_wr(cfg_r, reg_wdata, a_kind);
  wire        abort_set = wr_ctrl & ctrl_new[ABORT_BIT];

  wire        on_b     = ctrl_r[ON_BIT];
  wire [2:0]  mreq     = ctrl_r[MREQ_LSB +: 3];
  wire        cap_en   = ctrl_r[CAP_BIT];
  wire        stop_in_idle_b  = ctrl_r[STOP_IN_IDLE_BIT];
  wire [4:0]  dcnt     = ctrl_r[4:0];

  wire        wakf_en  = cfg_r[WAKF_BIT];
  wire [2:0]  ph2_f    = cfg_r[PH2_LSB +: 3];
  wire        ph2_sel  = cfg_r[PH2SEL_BIT];
  wire        sam_b    = cfg_r[SAM_BIT];
  wire [2:0]  ph1_f    = cfg_r[PH1_LSB +: 3];
  wire [2:0]  prop_f   = cfg_r[PROP_LSB +: 3];
  wire [1:0]  sjw_f    = cfg_r[SJW_LSB +: 2];
  wire [5:0]  brp_f    = cfg_r[5:0];

  // ---------------------------------------------------------------
  // Register updates
  // ---------------------------------------------------------------
  assign ctrl_nxt = wr_ctrl
                  ? (ctrl_r & ~CTRL_WMASK) | (ctrl_new & CTRL_WMASK)
                  : ctrl_r;
  assign cfg_nxt  = wr_cfg
                  ? (cfg_r & ~CFG_WMASK) | (cfg_new & CFG_WMASK)
                  : cfg_r;
  // Set wins over the hardware clear
  assign abort_nxt = abort_set | (abort_r & ~tx_abort_done);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r  <= CTRL_RST;
      cfg_r   <= CFG_RST;
      abort_r <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      cfg_r   <= cfg_nxt;
      abort_r <= abort_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Enable, busy and run
  // ---------------------------------------------------------------
  // Busy falls only after the running transaction has ended
  wire busy_nxt = on_b | (busy_r & xact_busy);
  wire run      = busy_r & ~(stop_in_idle_b & sys_idle);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Mode handshake
  // ---------------------------------------------------------------
  wire req_legal = (mreq != MODE_RSV5) & (mreq != MODE_RSV6);
  wire req_new   = req_legal & (mreq != mstat_r);
  wire take_mode = (mst_r == CMBT_WAIT) & req_new & mode_ready;

  always_comb begin
    mst_nxt = mst_r;
    unique case (mst_r)
      CMBT_RUN: begin
        if (req_new) begin
          mst_nxt = CMBT_WAIT;
        end
      end
      CMBT_WAIT: begin
        if (take_mode | ~req_new) begin
          mst_nxt = CMBT_RUN;
        end
      end
      default: begin
        mst_nxt = CMBT_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mst_r   <= CMBT_RUN;
      mstat_r <= MODE_CONFIG;
      mode_change_flag_r <= 1'b0;
    end else begin
      mst_r   <= mst_nxt;
      mode_change_flag_r <= take_mode;
      if (take_mode) begin
        mstat_r <= mreq;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  wire [31:0] ctrl_view =
    {4'h0, abort_r, mreq, mstat_r, cap_en, 4'h0,
     on_b, 1'b0, stop_in_idle_b, 1'b0, busy_r, 6'h00, dcnt};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_view
                     : hit_cfg  ? (cfg_r & CFG_WMASK)
                     : 32'h0000_0000;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Timestamp timer and capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tmr_r <= '0;
      cap_r <= '0;
    end else begin
      if (cap_en & run) begin
        tmr_r <= tmr_r + 1'b1;
      end
      if (cap_en & run & rx_valid_msg) begin
        cap_r <= tmr_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // Wake-up line filter
  // ---------------------------------------------------------------
  localparam logic [7:0] WAKE_CYC = 8'(WAKE_FILT_CYC);
  wire rx_same = (can_rx == rx_last_r);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_last_r <= 1'b1;
      stab_r    <= 8'h00;
      wake_r    <= 1'b1;
    end else begin
      rx_last_r <= can_rx;
      if (!rx_same) begin
        stab_r <= 8'h00;
      end else if (stab_r < WAKE_CYC) begin
        stab_r <= stab_r + 8'h01;
      end else begin
        wake_r <= rx_last_r;
      end
    end
  end

  assign wake_line = wakf_en ? wake_r : can_rx;

  // ---------------------------------------------------------------
  // Segment lengths
  // ---------------------------------------------------------------
  wire [2:0] ph2_auto = (ph1_f > IPT_FIELD) ? ph1_f : IPT_FIELD;
  wire [2:0] ph2_eff  = ph2_sel ? ph2_f : ph2_auto;
  wire [3:0] ph1_len  = {1'b0, ph1_f} + 4'h1;
  wire [3:0] ph2_len  = {1'b0, ph2_eff} + 4'h1;
  wire [3:0] prop_len = {1'b0, prop_f} + 4'h1;
  // Quanta at which the sample point and the bit end fall
  wire [4:0] smp_tq   = 5'(prop_len) + 5'(ph1_len);
  wire [4:0] end_tq   = smp_tq + 5'(ph2_len);

  // ---------------------------------------------------------------
  // Quantum divider: tick every 2 x (prescaler + 1) clocks
  // ---------------------------------------------------------------
  wire div_wrap = (div_r == brp_f);
  wire tick     = run & div_wrap & half_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_r  <= 6'h00;
      half_r <= 1'b0;
    end else if (!run) begin
      div_r  <= 6'h00;
      half_r <= 1'b0;
    end else if (div_wrap) begin
      div_r  <= 6'h00;
      half_r <= ~half_r;
    end else begin
      div_r  <= div_r + 6'h01;
    end
  end

  // ---------------------------------------------------------------
  // Bit-phase sequencer and sampler
  // ---------------------------------------------------------------
  wire at_smp = tick & (tq_r == smp_tq);
  wire at_end = tick & (tq_r == end_tq);
  // Triple sampling takes the quanta just before and at the point
  wire [2:0] smp_win = {smp_r[1:0], can_rx};
  wire maj = (smp_win[0] & smp_win[1]) | (smp_win[0] & smp_win[2])
           | (smp_win[1] & smp_win[2]);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tq_r  <= 5'h00;
      smp_r <= 3'h7;
      bit_r <= 1'b1;
    end else begin
      if (!run) begin
        tq_r <= 5'h00;
      end else if (at_end) begin
        tq_r <= 5'h00;
      end else if (tick) begin
        tq_r <= tq_r + 5'h01;
      end
      if (tick) begin
        smp_r <= smp_win;
      end
      if (at_smp) begin
        bit_r <= sam_b ? maj : can_rx;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata          = rdata_r;
  assign tx_abort_req       = abort_r;
  assign module_run         = run;
  assign mode_status        = mstat_r;
  assign mode_change_flag   = mode_change_flag_r;
  assign rx_timestamp       = cap_r;
  assign timestamp_timer    = tmr_r;
  // Invalid counts fall back to no data comparison
  assign data_compare_count = (dcnt > DCNT_MAX) ? 5'h00 : dcnt;
  assign tq_tick            = tick;
  assign sample_point       = at_smp;
  assign sampled_bit        = bit_r;
  assign bit_end            = at_end;
  assign phase_seg1_len     = ph1_len;
  assign phase_seg2_len     = ph2_len;
  assign prop_seg_len       = prop_len;
  assign resync_jump_width  = {1'b0, sjw_f} + 3'h1;
  assign triple_sample_en   = sam_b;

endmodule

/* logic/cmbt_pkg.sv */
/*
  Constants for the CAN mode and bit-timing control block.
  Assumes a 32-bit register port with 8-bit byte addresses.
*/
package cmbt_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] CTRL_BASE = 4'h0;
  localparam logic [3:0] CFG_BASE  = 4'h1;
  localparam logic [1:0] AL_WR     = 2'h0;
  localparam logic [1:0] AL_CLR    = 2'h1;
  localparam logic [1:0] AL_SET    = 2'h2;
  localparam logic [1:0] AL_INV    = 2'h3;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ABORT_BIT  = 27;
  localparam int MREQ_LSB   = 24;
  localparam int MSTAT_LSB  = 21;
  localparam int CAP_BIT    = 20;
  localparam int ON_BIT     = 15;
  localparam int STOP_IN_IDLE_BIT  = 13;
  localparam int BUSY_BIT   = 11;
  localparam int WAKF_BIT   = 22;
  localparam int PH2_LSB    = 16;
  localparam int PH2SEL_BIT = 15;
  localparam int SAM_BIT    = 14;
  localparam int PH1_LSB    = 11;
  localparam int PROP_LSB   = 8;
  localparam int SJW_LSB    = 6;

  localparam logic [31:0] CTRL_WMASK = 32'h0710_a01f;
  localparam logic [31:0] CFG_WMASK  = 32'h0047_ffff;
  localparam logic [31:0] CTRL_RST   = 32'h0400_0000;
  localparam logic [31:0] CFG_RST    = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Modes, limits and timing
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_NORMAL  = 3'h0;
  localparam logic [2:0] MODE_DISABLE = 3'h1;
  localparam logic [2:0] MODE_LOOP    = 3'h2;
  localparam logic [2:0] MODE_LISTEN  = 3'h3;
  localparam logic [2:0] MODE_CONFIG  = 3'h4;
  localparam logic [2:0] MODE_RSV5    = 3'h5;
  localparam logic [2:0] MODE_RSV6    = 3'h6;
  localparam logic [2:0] MODE_ALL     = 3'h7;
  localparam logic [4:0] DCNT_MAX     = 5'h12;
  localparam logic [2:0] IPT_FIELD    = 3'h1;
  localparam int         WAKE_FILT_NS = 200;
  localparam int         CLK_NS       = 40;
  localparam int         WAKE_FILT_CYC = (WAKE_FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int         TS_W         = 16;

  typedef enum logic [1:0] {
    CMBT_RUN  = 2'b01,
    CMBT_WAIT = 2'b10
  } cmbt_mode_st_t;

endpackage

/* tb/cmbt_ctrl_monitor.sv */
/*
  Checker for the CAN mode and bit-timing control block.
  Assumes it is bound to cmbt_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
module cmbt_ctrl_monitor (
  input wire logic                      clk,
  input wire logic                      sys_rst,
  input wire logic [7:0]                reg_addr,
  input wire logic [31:0]               reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [31:0]               reg_rdata,
  input wire logic                      tx_abort_req,
  input wire logic                      tx_abort_done,
  input wire logic                      rx_valid_msg,
  input wire logic                      module_run,
  input wire logic [2:0]                mode_status,
  input wire logic                      mode_change_flag,
  input wire logic [cmbt_pkg::TS_W-1:0] rx_timestamp,
  input wire logic [cmbt_pkg::TS_W-1:0] timestamp_timer,
  input wire logic [4:0]                data_compare_count,
  input wire logic                      tq_tick,
  input wire logic [3:0]                prop_seg_len,
  input wire logic [2:0]                resync_jump_width
);
  import cmbt_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire [2:0] wr_prop = reg_wdata[PROP_LSB +: 3];
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  sequence s_flag_pulse;
    mode_change_flag ##1 !mode_change_flag;
  endsequence
  abort_set_a: assert property (reg_wr && reg_addr == 8'h08 &&
    reg_wdata[ABORT_BIT] |=> tx_abort_req) else $error("abort not set");
  abort_hold_a: assert property (tx_abort_req && !tx_abort_done
    |=> tx_abort_req) else $error("abort dropped early");
  abort_clear_a: assert property (tx_abort_req && tx_abort_done &&
    !(reg_wr && reg_wdata[ABORT_BIT]) |=> !tx_abort_req)
    else $error("abort not cleared");
  read_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  mode_flag_a: assert property ($changed(mode_status) |->
    s_flag_pulse) else $error("mode change without flag pulse");
  mode_legal_a: assert property (mode_status != MODE_RSV5 &&
    mode_status != MODE_RSV6) else $error("reserved mode in effect");
  cfg_lock_a: assert property (reg_wr && reg_addr[7:4] == CFG_BASE &&
    mode_status != MODE_CONFIG |=> $stable(prop_seg_len) &&
    $stable(resync_jump_width)) else $error("timing changed outside config");
  prop_len_a: assert property (reg_wr && reg_addr == 8'h10 &&
    mode_status == MODE_CONFIG |=>
    prop_seg_len == {1'b0, $past(wr_prop)} + 4'h1)
    else $error("prop segment length wrong");
  timer_halt_a: assert property (!module_run |=>
    $stable(timestamp_timer)) else $error("timer ran while stopped");
  timer_step_a: assert property ($changed(timestamp_timer) |->
    timestamp_timer == $past(timestamp_timer) + 1'b1)
    else $error("timer jumped");
  ts_capture_a: assert property ($changed(rx_timestamp) |->
    $past(rx_valid_msg) && rx_timestamp == $past(timestamp_timer))
    else $error("bad timestamp capture");
  dcnt_range_a: assert property (data_compare_count <= DCNT_MAX)
    else $error("compare count out of range");
  tick_gap_a: assert property (tq_tick |=> !tq_tick)
    else $error("quantum shorter than two clocks");
endmodule

bind cmbt_ctrl cmbt_ctrl_monitor mon (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_abort_req(tx_abort_req),
  .tx_abort_done(tx_abort_done), .rx_valid_msg(rx_valid_msg),
  .module_run(module_run), .mode_status(mode_status),
  .mode_change_flag(mode_change_flag), .rx_timestamp(rx_timestamp),
  .timestamp_timer(timestamp_timer),
  .data_compare_count(data_compare_count), .tq_tick(tq_tick),
  .prop_seg_len(prop_seg_len), .resync_jump_width(resync_jump_width));

/* tb/cmbt_ctrl_tb.sv */
/*
  Self-checking bench for the CAN mode and bit-timing control block.
  Assumes the register port answers a read in the following cycle.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  errors++; $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module cmbt_ctrl_tb;
  import cmbt_pkg::*;
  logic        clk, sys_rst, reg_wr, reg_rd, xact_busy, sys_idle, slow;
  logic        rx_valid_msg, can_rx, tx_abort_done, mode_ready;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic        tx_abort_req, module_run, mode_change_flag, wake_line;
  logic        tq_tick, triple_sample_en, sample_point, bit_end, sampled_bit;
  logic [2:0]  mode_status, resync_jump_width;
  logic [15:0] rx_timestamp, timestamp_timer, t;
  logic [4:0]  data_compare_count;
  logic [3:0]  phase_seg1_len, phase_seg2_len, prop_seg_len;
  logic [2:0]  modes [6];
  int          errors, samples_checked, n;

  cmbt_ctrl dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .xact_busy(xact_busy),
    .tx_abort_done(tx_abort_done), .mode_ready(mode_ready),
    .sys_idle(sys_idle), .rx_valid_msg(rx_valid_msg), .can_rx(can_rx),
    .tx_abort_req(tx_abort_req), .module_run(module_run),
    .mode_status(mode_status), .mode_change_flag(mode_change_flag),
    .rx_timestamp(rx_timestamp), .timestamp_timer(timestamp_timer),
    .wake_line(wake_line), .data_compare_count(data_compare_count),
    .tq_tick(tq_tick), .sample_point(sample_point),
    .sampled_bit(sampled_bit), .bit_end(bit_end),
    .phase_seg1_len(phase_seg1_len), .phase_seg2_len(phase_seg2_len),
    .prop_seg_len(prop_seg_len), .resync_jump_width(resync_jump_width),
    .triple_sample_en(triple_sample_en));
  cmbt_engine_model eng (.clk(clk), .sys_rst(sys_rst),
    .tx_abort_req(tx_abort_req), .slow(slow),
    .tx_abort_done(tx_abort_done), .mode_ready(mode_ready));

  always #20 clk = ~clk;
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end
  initial begin
    {clk, reg_wr, reg_rd, xact_busy, sys_idle, slow, rx_valid_msg} = '0;
    reg_addr = 8'h0; reg_wdata = 32'h0; can_rx = 1'b1; sys_rst = 1'b1;
    modes = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4};
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h00, d); `CHK(d, 32'h0480_0000)
    rd(8'h10, d); `CHK(d, 32'h0)
    rd(8'h20, d); `CHK(d, 32'h0)
    note("reset");
    wr(8'h10, 32'h0047_ffff); @(negedge clk);
    `CHK({prop_seg_len, phase_seg1_len, phase_seg2_len}, 12'h888)
    `CHK({resync_jump_width, triple_sample_en}, 4'h9)
    wr(8'h14, 32'h0000_b800); @(negedge clk);
    `CHK({phase_seg1_len, phase_seg2_len}, 8'h12)
    wr(8'h18, 32'h0000_2000); @(negedge clk);
    `CHK({phase_seg1_len, phase_seg2_len}, 8'h55)
    wr(8'h1c, 32'h0000_00c0); rd(8'h10, d);
    `CHK(d, 32'h0047_673f)
    wr(8'h10, 32'h0002_9a01);
    note("timing");
    wr(8'h08, 32'h0000_8000); rd(8'h00, d);
    `CHK(d, 32'h0480_8800)
    while (tq_tick !== 1'b1) @(negedge clk);
    @(negedge clk); n = 1;
    while (tq_tick !== 1'b1 && n < 20) begin @(negedge clk); n++; end
    `CHK(n, 4)
    while (bit_end !== 1'b1) @(negedge clk);
    @(posedge clk); can_rx <= 1'b0; n = 0;
    do begin @(negedge clk); n++; end while (sample_point !== 1'b1 && n < 60);
    `CHK(n, 32)
    do begin @(negedge clk); n++; end while (bit_end !== 1'b1 && n < 60);
    `CHK(n, 44)
    `CHK(sampled_bit, 1'b0)
    @(posedge clk); can_rx <= 1'b1;
    note("prescaler");
    for (int i = 0; i < 6; i++) begin
      @(posedge clk); slow <= i[0];
      wr(8'h00, {5'h0, modes[i], 24'h8000});
      n = 0;
      while (mode_change_flag !== 1'b1 && n < 40) begin
        @(negedge clk); n++;
      end
      `CHK(mode_status, modes[i])
      rd(8'h00, d); `CHK(d[23:21], modes[i])
      if (i == 0) begin
        wr(8'h10, 32'h0000_0700); rd(8'h10, d); `CHK(d, 32'h0002_9a01)
      end
    end
    for (int m = 5; m < 7; m++) begin
      wr(8'h00, {5'h0, 3'(m), 24'h8000}); repeat (10) @(negedge clk);
      `CHK(mode_status, MODE_CONFIG)
    end
    wr(8'h00, 32'h0400_8000);
    note("modes");
    wr(8'h08, 32'h0800_0000); @(negedge clk);
    `CHK(tx_abort_req, 1'b1)
    wr(8'h04, 32'h0800_0000); rd(8'h00, d); `CHK(d[27], 1'b1)
    n = 0;
    while (tx_abort_req !== 1'b0 && n < 30) begin @(negedge clk); n++; end
    `CHK(tx_abort_req, 1'b0)
    note("abort");
    wr(8'h08, 32'h0000_0012); @(negedge clk); `CHK(data_compare_count, 5'h12)
    wr(8'h08, 32'h0000_0001); @(negedge clk); `CHK(data_compare_count, 5'h0)
    wr(8'h04, 32'h0000_001f);
    wr(8'h08, 32'h0010_0000); @(negedge clk); t = timestamp_timer;
    @(negedge clk); `CHK(timestamp_timer, t + 16'h1)
    @(posedge clk); rx_valid_msg <= 1'b1;
    @(negedge clk); t = timestamp_timer;
    @(posedge clk); rx_valid_msg <= 1'b0;
    @(negedge clk); `CHK(rx_timestamp, t)
    wr(8'h04, 32'h0010_0000); @(negedge clk); t = timestamp_timer;
    repeat (5) @(negedge clk); `CHK(timestamp_timer, t)
    note("timestamp");
    @(posedge clk); sys_idle <= 1'b1;
    @(negedge clk); `CHK(module_run, 1'b1)
    wr(8'h08, 32'h0000_2000);
    @(negedge clk); `CHK(module_run, 1'b0)
    @(posedge clk); sys_idle <= 1'b0;
    @(negedge clk); `CHK(module_run, 1'b1)
    wr(8'h18, 32'h0040_0000);
    @(posedge clk); can_rx <= 1'b0;
    @(negedge clk); `CHK(wake_line, 1'b1)
    repeat (8) @(negedge clk); `CHK(wake_line, 1'b0)
    @(posedge clk); can_rx <= 1'b1;
    wr(8'h14, 32'h0040_0000); @(negedge clk); `CHK(wake_line, 1'b1)
    @(posedge clk); can_rx <= 1'b0;
    @(negedge clk); `CHK(wake_line, 1'b0)
    note("idle and wake");
    @(posedge clk); xact_busy <= 1'b1;
    wr(8'h04, 32'h0000_8000); rd(8'h00, d); `CHK(d[11], 1'b1)
    @(posedge clk); xact_busy <= 1'b0;
    n = 0;
    do begin rd(8'h00, d); n++; end while (d[11] !== 1'b0 && n < 10);
    `CHK(d[11], 1'b0)
    `CHK(module_run, 1'b0)
    note("disable");
    end_of_test();
  end
endmodule

/* tb/cmbt_engine_model.sv */
/*
  Behavioural protocol engine beside the control block.
  Assumes the abort request is a level held until completion.
*/
`timescale 1ns/1ps
module cmbt_engine_model (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic tx_abort_req,
  input  wire logic slow,
  output logic      tx_abort_done,
  output logic      mode_ready
);
  logic [3:0] abort_cnt_r;
  logic [1:0] pace_r;
  // Safe point every edge, or one edge in four when slow
  assign mode_ready    = !slow || (pace_r == 2'h3);
  // All buffers report aborted some cycles after the request
  assign tx_abort_done = tx_abort_req && (abort_cnt_r == 4'h8);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      abort_cnt_r <= 4'h0;
      pace_r      <= 2'h0;
    end else begin
      pace_r <= pace_r + 2'h1;
      if (!tx_abort_req)
        abort_cnt_r <= 4'h0;
      else if (abort_cnt_r != 4'h8)
        abort_cnt_r <= abort_cnt_r + 4'h1;
    end
  end
endmodule
